// *** fbiop_pkg.sv ***
package fbiop_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] FBIOP_DIR_ADDR = 4'h0;   // Direction, write only
   localparam logic [3:0] FBIOP_LATCH_ADDR = 4'h4; // Output latch
   localparam logic [3:0] FBIOP_RDBK_ADDR = 4'h8;  // Pin readback
   localparam logic [3:0] FBIOP_DRAIN_ADDR = 4'hc; // Drain select
   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] FBIOP_IMPL_MASK = 8'h47; // Bits 6, 2, 1, 0
   localparam logic [7:0] FBIOP_PORT_RST = 8'h00;  // All fields reset low
   localparam int FBIOP_PULLUP_BIT = 6;           // Pull-up control pin
   localparam int FBIOP_SHARED_BIT = 2;           // Serial clock shared pin
   localparam logic [1:0] FBIOP_RESP_OKAY = 2'h0;
   localparam logic [1:0] FBIOP_RESP_SLVERR = 2'h2;
endpackage

// *** fbiop_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for the pin levels
module fbiop_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg; // First stage, read only by the second

   // ----------------------------------------------------------------
   // Double flop
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// *** fbiop_port.sv ***
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Four-bit I/O port with AXI4-Lite registers
module fbiop_port (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [3:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Serial channel controls, same clock domain
   input wire logic clock_enable_high_in,
   input wire logic clock_enable_low_in,
   input wire logic clocked_mode_in,
   input wire logic serial_clock_out_in,   // Clock from the serial channel
   output logic serial_clock_pin_out,      // Synchronised clock into the channel
   output logic external_interrupt_four_out, // Synchronised shared pin level
   // Pins: value, and enable that is low while driving
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] pin_direction_reg; // Write only
   logic [7:0] output_latch_reg;
   logic [7:0] drain_select_reg;
   logic [7:0] pin_sync;          // Pin levels after two flops
   logic aw_hold_reg;             // Write address captured
   logic w_hold_reg;              // Write data captured
   logic [3:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic do_write;
   logic [7:0] drive_en;          // Pin is an output in its current role
   logic [7:0] drive_val;         // Level the pin wants
   logic [7:0] readback;
   logic shared_serial_in;        // Shared pin is the serial clock input
   logic shared_serial_out;       // Shared pin is the serial clock output

   fbiop_sync #(.WIDTH(8)) u_sync (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   // Address and data may arrive in either order; each is held once taken
   assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid_out;

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= fbiop_pkg::FBIOP_RESP_OKAY;
      end else begin
         s_axi_awready_out <= !aw_hold_reg && !s_axi_awready_out && s_axi_awvalid_in;
         s_axi_wready_out <= !w_hold_reg && !s_axi_wready_out && s_axi_wvalid_in;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_in;
            wstrb_reg <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            // Readback is read only; writes to it are refused
            if (awaddr_reg == fbiop_pkg::FBIOP_DIR_ADDR ||
                awaddr_reg == fbiop_pkg::FBIOP_LATCH_ADDR ||
                awaddr_reg == fbiop_pkg::FBIOP_DRAIN_ADDR) begin
               s_axi_bresp_out <= fbiop_pkg::FBIOP_RESP_OKAY;
            end else begin
               s_axi_bresp_out <= fbiop_pkg::FBIOP_RESP_SLVERR;
            end
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   // Only byte lane 0 carries fields; reserved bits never store
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_direction_reg <= fbiop_pkg::FBIOP_PORT_RST;
         output_latch_reg <= fbiop_pkg::FBIOP_PORT_RST;
         drain_select_reg <= fbiop_pkg::FBIOP_PORT_RST;
      end else if (do_write && wstrb_reg[0]) begin
         case (awaddr_reg)
            fbiop_pkg::FBIOP_DIR_ADDR: begin
               pin_direction_reg <= wdata_reg[7:0] & fbiop_pkg::FBIOP_IMPL_MASK;
            end
            fbiop_pkg::FBIOP_LATCH_ADDR: begin
               output_latch_reg <= wdata_reg[7:0] & fbiop_pkg::FBIOP_IMPL_MASK;
            end
            fbiop_pkg::FBIOP_DRAIN_ADDR: begin
               drain_select_reg <= wdata_reg[7:0] & fbiop_pkg::FBIOP_IMPL_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin role selection
   // ----------------------------------------------------------------
   // Clock-enable-high wins over the other two serial controls
   assign shared_serial_in = clock_enable_high_in;
   assign shared_serial_out = !clock_enable_high_in &&
                              (clocked_mode_in || clock_enable_low_in);

   always_comb begin
      drive_en = pin_direction_reg;
      drive_val = output_latch_reg;
      if (shared_serial_in) begin
         drive_en[fbiop_pkg::FBIOP_SHARED_BIT] = 1'b0;
      end else if (shared_serial_out) begin
         drive_en[fbiop_pkg::FBIOP_SHARED_BIT] = 1'b1;
         drive_val[fbiop_pkg::FBIOP_SHARED_BIT] = serial_clock_out_in;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // Open drain releases the pin instead of driving high
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_out <= '0;
         pin_oe_n_out <= '1;
      end else begin
         pin_out <= drive_val & fbiop_pkg::FBIOP_IMPL_MASK;
         pin_oe_n_out <= ~(drive_en & fbiop_pkg::FBIOP_IMPL_MASK &
                           ~(drain_select_reg & drive_val));
      end
   end

   // Synchronised shared pin feeds the serial channel and the interrupt
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         serial_clock_pin_out <= 1'b0;
         external_interrupt_four_out <= 1'b0;
      end else begin
         serial_clock_pin_out <= pin_sync[fbiop_pkg::FBIOP_SHARED_BIT];
         // Software must keep other functions off when using this
         external_interrupt_four_out <= pin_sync[fbiop_pkg::FBIOP_SHARED_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   // Reserved bits read as zero here
   assign readback = ((pin_direction_reg & output_latch_reg) |
                      (~pin_direction_reg & pin_sync)) &
                     fbiop_pkg::FBIOP_IMPL_MASK;

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= fbiop_pkg::FBIOP_RESP_OKAY;
      end else begin
         s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && s_axi_arvalid_in;
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= fbiop_pkg::FBIOP_RESP_OKAY;
            case (s_axi_araddr_in)
               fbiop_pkg::FBIOP_LATCH_ADDR: begin
                  s_axi_rdata_out <= {24'h000000, output_latch_reg};
               end
               fbiop_pkg::FBIOP_RDBK_ADDR: begin
                  s_axi_rdata_out <= {24'h000000, readback};
               end
               fbiop_pkg::FBIOP_DRAIN_ADDR: begin
                  s_axi_rdata_out <= {24'h000000, drain_select_reg};
               end
               default: begin
                  // Direction is write only, so it answers like a hole
                  s_axi_rdata_out <= '0;
                  s_axi_rresp_out <= fbiop_pkg::FBIOP_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence seq_latch_write;
      do_write && wstrb_reg[0] && awaddr_reg == fbiop_pkg::FBIOP_LATCH_ADDR;
   endsequence

   AST_DIR_RESET: assert property (@(posedge clk_sys_in)
      $rose(rstn_in) |-> pin_direction_reg == fbiop_pkg::FBIOP_PORT_RST)
      else $error("direction not zero after reset");
   AST_RESERVED: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      ((pin_direction_reg | output_latch_reg | drain_select_reg) &
       ~fbiop_pkg::FBIOP_IMPL_MASK) == 8'h00)
      else $error("reserved bit stored");
   AST_LATCH_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      seq_latch_write |=> output_latch_reg == ($past(wdata_reg[7:0]) & fbiop_pkg::FBIOP_IMPL_MASK))
      else $error("latch write lost");
   AST_PIN_FOLLOWS: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      seq_latch_write ##1 1'b1 |=>
      pin_out[fbiop_pkg::FBIOP_PULLUP_BIT] == output_latch_reg[fbiop_pkg::FBIOP_PULLUP_BIT])
      else $error("pin not following latch");
   AST_DRAIN_HIGH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      drain_select_reg[0] && output_latch_reg[0] |=> pin_oe_n_out[0])
      else $error("open drain drove high");
   AST_PULLUP_DIR: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !pin_direction_reg[fbiop_pkg::FBIOP_PULLUP_BIT] |=>
      pin_oe_n_out[fbiop_pkg::FBIOP_PULLUP_BIT])
      else $error("input pin driven");
   AST_SERIAL_IN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      clock_enable_high_in |=> pin_oe_n_out[2])
      else $error("serial clock input driven");
   AST_GENERAL: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !clock_enable_high_in && !clock_enable_low_in && !clocked_mode_in &&
      !drain_select_reg[2] |=> pin_oe_n_out[2] == !$past(pin_direction_reg[2]))
      else $error("shared pin ignores direction");
   AST_READ_OUT: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s_axi_arvalid_in && s_axi_arready_out &&
      s_axi_araddr_in == fbiop_pkg::FBIOP_RDBK_ADDR && pin_direction_reg[1]
      |=> s_axi_rdata_out[1] == $past(output_latch_reg[1]))
      else $error("readback of output wrong");
   AST_READ_IN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s_axi_arvalid_in && s_axi_arready_out &&
      s_axi_araddr_in == fbiop_pkg::FBIOP_RDBK_ADDR && !pin_direction_reg[0]
      |=> s_axi_rdata_out[0] == $past(pin_sync[0]))
      else $error("readback of input wrong");

   // ----------------------------------------------------------------
   // Serial hand-over and pad checks
   // ----------------------------------------------------------------
   // Pin 2 handed to the serial channel as its clock output
   sequence seq_serial_drive;
      !clock_enable_high_in && (clocked_mode_in || clock_enable_low_in);
   endsequence

   // Same hand-over, with the high side of pin 2 left enabled
   sequence seq_serial_push_pull;
      !clock_enable_high_in && (clocked_mode_in || clock_enable_low_in) &&
      !drain_select_reg[fbiop_pkg::FBIOP_SHARED_BIT];
   endsequence

   // Latch written, then pin 1 still a push-pull general output
   sequence seq_latch_to_pin;
      seq_latch_write ##1 (pin_direction_reg[1] && !drain_select_reg[1]);
   endsequence

   // The serial level reaches the pad one edge after it is offered
   AST_SERIAL_OUT: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      seq_serial_drive |=> pin_out[fbiop_pkg::FBIOP_SHARED_BIT] == $past(serial_clock_out_in))
      else $error("serial clock level not on shared pin");
   // With push-pull drive the serial clock output must be enabled
   AST_SERIAL_EN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      seq_serial_push_pull |=> !pin_oe_n_out[fbiop_pkg::FBIOP_SHARED_BIT])
      else $error("serial clock output not driven");
   // The value written, two edges on, is what the pad carries
   AST_LATCH_TO_PIN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      seq_latch_to_pin |=> pin_out[1] == $past(wdata_reg[1], 2) && !pin_oe_n_out[1])
      else $error("latch value not driven on pin");
   // Push-pull output must pull high itself, no pull-up assumed
   AST_CMOS_HIGH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      pin_direction_reg[0] && output_latch_reg[0] && !drain_select_reg[0]
      |=> !pin_oe_n_out[0] && pin_out[0])
      else $error("push-pull pin not driving high");
   // Reserved pads stay released and low whatever software writes
   AST_PAD_RESERVED: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (pin_out & ~fbiop_pkg::FBIOP_IMPL_MASK) == 8'h00 &&
      (pin_oe_n_out & ~fbiop_pkg::FBIOP_IMPL_MASK) == ~fbiop_pkg::FBIOP_IMPL_MASK)
      else $error("reserved pad driven");
endmodule

// *** fbiop_pins_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Pad board: pull-ups and outside drivers
// ------------------------------------------------
module fbiop_pins_model (
   input wire logic [7:0] pin_out_in,
   input wire logic [7:0] pin_oe_n_in,
   input wire logic [7:0] ext_drive_in,
   input wire logic [7:0] ext_level_in,
   output logic [7:0] pin_level_out
);
   // Port drive wins; outside parts drive only released pads, so no fight
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n_in[i]) begin
            pin_level_out[i] = pin_out_in[i];
         end else if (ext_drive_in[i]) begin
            pin_level_out[i] = ext_level_in[i]; // Released pad pulled by others
         end else begin
            pin_level_out[i] = 1'b1; // Pull-up keeps an idle pad defined
         end
      end
   end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
   // ------------------------------------------------
   // Signals
   // ------------------------------------------------
   localparam logic [3:0] A_DIR = fbiop_pkg::FBIOP_DIR_ADDR;
   localparam logic [3:0] A_LAT = fbiop_pkg::FBIOP_LATCH_ADDR;
   localparam logic [3:0] A_RBK = fbiop_pkg::FBIOP_RDBK_ADDR;
   localparam logic [3:0] A_DRN = fbiop_pkg::FBIOP_DRAIN_ADDR;
   logic clk_sys_in, rstn_in, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic ce_high, ce_low, cmode, sclk_tx, sclk_rx, int_four;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [7:0] pin_lvl, pin_drv, pin_oe_n, ext_drv, ext_lvl;
   int n_errors, cmp_count;
   fbiop_port fbiop_port_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .clock_enable_high_in(ce_high),
      .clock_enable_low_in(ce_low), .clocked_mode_in(cmode), .serial_clock_out_in(sclk_tx),
      .serial_clock_pin_out(sclk_rx), .external_interrupt_four_out(int_four),
      .pin_in(pin_lvl), .pin_out(pin_drv), .pin_oe_n_out(pin_oe_n));
   fbiop_pins_model fbiop_pins_model_inst (.pin_out_in(pin_drv), .pin_oe_n_in(pin_oe_n),
      .ext_drive_in(ext_drv), .ext_level_in(ext_lvl), .pin_level_out(pin_lvl));
   // 200 MHz system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Bounded wait ran out: count it and stop, a hung bus blocks all else
   task automatic hung();
      n_errors++;
      $display("ERROR bus answer expected within 64 cycles seen none");
      complete_run();
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
      int n;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk_sys_in);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 64) hung();
      r = bresp;
      bready <= 1'b0;
      @(posedge clk_sys_in); // Spacer so no signal is set twice in one step
   endtask
   task automatic axi_rd(input logic [3:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk_sys_in);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 64) hung();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic wr_ok(input logic [3:0] a, input logic [31:0] v);
      axi_wr(a, v);
      check("bresp", r, fbiop_pkg::FBIOP_RESP_OKAY);
   endtask
   task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] e);
      axi_rd(a);
      check(name, d, e);
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset_values();
      check("oe_n reset", pin_oe_n, 8'hff);
      check("pin_out reset", pin_drv, 8'h00);
      rd_chk("latch reset", A_LAT, 32'h0);
      rd_chk("drain reset", A_DRN, 32'h0);
   endtask
   // All bits written: only the four real pins may take it
   task automatic t_outputs();
      wr_ok(A_DIR, 32'hff); // Direction written whole, never merged
      wr_ok(A_LAT, 32'hff);
      repeat (2) @(posedge clk_sys_in);
      check("oe_n out", pin_oe_n, 8'hb8);
      check("pin_out", pin_drv, 8'h47);
      rd_chk("latch rd", A_LAT, 32'h47);
      rd_chk("rdbk out", A_RBK, 32'h47);
   endtask
   // Inputs through the synchroniser; pin 2 alone serves the interrupt
   task automatic t_inputs();
      wr_ok(A_DIR, 32'h0);
      ext_drv <= 8'h47;
      ext_lvl <= 8'h05;
      repeat (5) @(posedge clk_sys_in);
      check("oe_n in", pin_oe_n, 8'hff);
      rd_chk("rdbk in a", A_RBK, 32'h05);
      check("irq level hi", int_four, 1'b1);
      ext_lvl <= 8'h42;
      repeat (5) @(posedge clk_sys_in);
      rd_chk("rdbk in b", A_RBK, 32'h42);
      check("irq level lo", int_four, 1'b0);
   endtask
   // Open drain releases high bits; others pull those pads low
   task automatic t_drain();
      ext_lvl <= 8'h00;
      wr_ok(A_DIR, 32'h47);
      wr_ok(A_LAT, 32'h41);
      wr_ok(A_DRN, 32'hff);
      repeat (5) @(posedge clk_sys_in);
      check("oe_n drain", pin_oe_n, 8'hf9);
      check("low side", pin_drv & 8'h06, 8'h00);
      rd_chk("rdbk latch", A_RBK, 32'h41);
      rd_chk("drain rd", A_DRN, 32'h47);
      wr_ok(A_DRN, 32'h0);
      repeat (2) @(posedge clk_sys_in);
      check("oe_n cmos", pin_oe_n, 8'hb8);
      check("pin cmos", pin_drv, 8'h41);
   endtask
   // Pin 2 ownership with no serial control and with each one alone; outside holds it low,
   // so as input it reads low against both the pull-up and the serial clock
   task automatic t_serial();
      logic [2:0] md [4] = '{3'b000, 3'b010, 3'b001, 3'b100};
      logic eoe [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
      logic elv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      ext_drv <= 8'h04;
      ext_lvl <= 8'h00;
      sclk_tx <= 1'b1;
      wr_ok(A_LAT, 32'h0);
      for (int i = 0; i < 4; i++) begin
         {ce_high, ce_low, cmode} <= md[i];
         repeat (6) @(posedge clk_sys_in);
         check("pin2 oe_n", pin_oe_n[2], eoe[i]);
         check("pin2 level", sclk_rx, elv[i]);
      end
      {ce_high, ce_low, cmode} <= 3'b000;
      @(posedge clk_sys_in);
   endtask
   // Accesses the map refuses
   task automatic t_refused();
      axi_wr(A_RBK, 32'h47);
      check("rdbk write", r, fbiop_pkg::FBIOP_RESP_SLVERR);
      axi_rd(A_DIR);
      check("dir read", r, fbiop_pkg::FBIOP_RESP_SLVERR);
      axi_rd(4'h6);
      check("unmapped", r, fbiop_pkg::FBIOP_RESP_SLVERR);
      rd_chk("latch kept", A_LAT, 32'h0);
   endtask
   // Reset in mid-run returns every pad to input
   task automatic t_midreset();
      wr_ok(A_LAT, 32'h47);
      rstn_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      check("oe_n rerst", pin_oe_n, 8'hff);
      check("out rerst", pin_drv, 8'h00);
      rstn_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_chk("latch rerst", A_LAT, 32'h0);
   endtask
   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      {rstn_in, awvalid, wvalid, bready, arvalid, rready} <= 6'h0;
      {ce_high, ce_low, cmode, sclk_tx} <= 4'h0;
      {awaddr, araddr, wdata} <= 40'h0;
      wstrb <= 4'hf;
      ext_drv <= 8'h00;
      ext_lvl <= 8'h00;
      repeat (20) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      @(posedge clk_sys_in);
      t_reset_values();
      t_outputs();
      t_inputs();
      t_drain();
      t_serial();
      t_refused();
      t_midreset();
      complete_run();
   end
endmodule
